// ---- tws_defs.svh ----
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH
// Purpose: constants of the two-wire slave transmitter
// Assumes: 32-bit APB word registers
// Notes: status codes sit in bits 7:3, prescaler bits read zero
`define TWS_OFF_CTRL 12'h000
`define TWS_OFF_STAT 12'h004
`define TWS_OFF_DATA 12'h008
`define TWS_OFF_ADDR 12'h00C
`define TWS_OFF_IRQ 12'h010
`define TWS_OFF_MASK 12'h014
`define TWS_ST_OWN_ADDRESS_READ 8'hA8
`define TWS_ST_ARB_R 8'hB0
`define TWS_ST_DACK 8'hB8
`define TWS_ST_DNACK 8'hC0
`define TWS_ST_LAST 8'hC8
`define TWS_ST_IDLE 8'hF8
`define TWS_ST_BERR 8'h00
`define TWS_CB_FLAG 7
`define TWS_CB_ACK 6
`define TWS_CB_START 5
`define TWS_CB_STOP 4
`define TWS_CB_EN 2
`define TWS_CB_ARB 0
`define TWS_GCA 7'h00
`define TWS_IRQ_FLAG 0
`define TWS_IRQ_BERR 1
`define TWS_BIT_LAST 3'h7
`endif

// ---- tws_pkg.sv ----
// Purpose: shared types of the two-wire slave transmitter
// Assumes: nothing
// Notes: control bits travel as one packed struct
package tws_pkg;
   typedef struct packed {
      logic flag;
      logic ackEnable;
      logic startRequest;
      logic stopRequest;
      logic rsvd;
      logic enable;
      logic rsvd2;
      logic arbLost;
   } tws_ctrl_t;
   typedef enum logic [2:0] {
      TWS_IDLE = 3'b000,
      TWS_ADDR = 3'b001,
      TWS_AACK = 3'b010,
      TWS_TXD = 3'b011,
      TWS_RACK = 3'b100,
      TWS_WAIT = 3'b101,
      TWS_IGN = 3'b110
   } tws_state_t;
endpackage

// ---- tws_sync.sv ----
// Purpose: two-flop synchroniser and edge finder for one bus line
// Assumes: line idles high
// Notes: edges come from the second and third flops only
module tws_sync (
   input wire logic clk,
   input wire logic reset,
   input wire logic lineIn,
   output logic lineOut,
   output logic rise,
   output logic fall
);
   logic meta_reg;
   logic sync_reg;
   logic old_reg;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         old_reg <= 1'b1;
      end else begin
         meta_reg <= lineIn;
         sync_reg <= meta_reg;
         old_reg <= sync_reg;
      end
   end
   assign lineOut = sync_reg;
   assign rise = sync_reg & ~old_reg;
   assign fall = ~sync_reg & old_reg;
endmodule

// ---- tws_apb.sv ----
// Purpose: APB slave front end, one-cycle answer
// Assumes: 32-bit data, word aligned
// Notes: unmapped addresses read zero and flag pslverr
module tws_apb (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   output logic pready,
   output logic wrStrobe,
   output logic rdStrobe
);
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & ~penable;
      end
   end
   assign wrStrobe = psel & penable & pready;
   assign rdStrobe = psel & ~penable;
endmodule

// ---- tws_top.sv ----
// Purpose: two-wire slave transmitter with status-driven control
// Assumes: clk 10 MHz, bus lines sampled by clk, APB registers
// Notes: master mode is outside; arbitration loss arrives as a control bit
// What this block does
// RULE1: own read address acked: flag, A8
// RULE2: arbitration lost then read-addressed: B0
// RULE3: byte acked with ack enable: B8
// RULE4: software loads byte, clears flag; ack picks last
// RULE5: byte not acked: C0, wait software
// RULE6: last byte acked anyway: C8
// RULE7: afterwards address recognised only per enables
// RULE8: start request honoured when bus free
// RULE9: software leaves stop clear, no data write
// RULE10: status reads F8 while flag clear
// RULE11: misplaced start or stop: status 00
// RULE12: bus error sets the flag
// RULE13: software recovers with stop plus flag clear
// RULE14: recovery clears stop, keeps other bits
// RULE15: recovery releases lines, sends no stop
// RULE16: prescaler bits read zero
// RULE17: reads after last byte get ones
// RULE18: clock held low while flag set; not held while status reads 00
`include "tws_defs.svh"
module tws_top (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sclIn,
   output logic sclOut,
   output logic sclOe,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   output logic startPending,
   output logic irq
);
   tws_pkg::tws_ctrl_t ctrl_reg;
   tws_pkg::tws_state_t state_reg;
   logic [7:0] status_reg, data_reg, shift_reg, addr_reg;
   logic [2:0] bit_reg;
   logic [1:0] irqStat_reg;
   logic [1:0] irqMask_reg;
   logic lastByte_reg;
   logic sdaDrive_reg;
   logic sclHold_reg;
   logic scl, sclRise, sclFall;
   logic sda, sdaRise, sdaFall;
   logic wrStrobe, rdStrobe, readyInt;
   logic startCond, stopCond, flagClear;
   logic hit, inFrame, setFlag;
   logic [7:0] setCode;
   logic busBusy_reg;
   tws_sync uScl (.clk(clk), .reset(reset), .lineIn(sclIn), .lineOut(scl),
      .rise(sclRise), .fall(sclFall));
   tws_sync uSda (.clk(clk), .reset(reset), .lineIn(sdaIn), .lineOut(sda),
      .rise(sdaRise), .fall(sdaFall));
   tws_apb uApb (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .paddr(paddr), .pready(readyInt), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe));
   assign pready = readyInt;
   assign startCond = sdaFall & scl;
   assign stopCond = sdaRise & scl;
   assign flagClear = wrStrobe & pwrite & (paddr == `TWS_OFF_CTRL) & pwdata[`TWS_CB_FLAG];
   assign inFrame = (state_reg != tws_pkg::TWS_IDLE) & (state_reg != tws_pkg::TWS_IGN);
   // own address needs ack enable; general call also needs its enable
   assign hit = ctrl_reg.ackEnable & ((shift_reg[7:1] == addr_reg[7:1]) |
      (addr_reg[0] & (shift_reg[7:1] == `TWS_GCA))); // RULE7
   // bit-level engine; status events are reported through setFlag and setCode
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= tws_pkg::TWS_IDLE;
         shift_reg <= 8'h00;
         bit_reg <= 3'h0;
         sdaDrive_reg <= 1'b0;
         lastByte_reg <= 1'b0;
         setFlag <= 1'b0;
         setCode <= `TWS_ST_IDLE;
      end else begin
         setFlag <= 1'b0;
         if (!ctrl_reg.enable) begin
            state_reg <= tws_pkg::TWS_IDLE;
            sdaDrive_reg <= 1'b0;
         end else if ((startCond | stopCond) & inFrame & (state_reg != tws_pkg::TWS_WAIT)) begin
            state_reg <= tws_pkg::TWS_WAIT; // RULE11
            sdaDrive_reg <= 1'b0;
            setFlag <= 1'b1; // RULE12
            setCode <= `TWS_ST_BERR; // RULE11
         end else if (startCond) begin
            state_reg <= tws_pkg::TWS_ADDR;
            bit_reg <= 3'h0;
            sdaDrive_reg <= 1'b0;
         end else if (stopCond) begin
            state_reg <= tws_pkg::TWS_IDLE;
            sdaDrive_reg <= 1'b0;
         end else begin
            case (state_reg)
               tws_pkg::TWS_ADDR: begin
                  if (sclRise) begin
                     shift_reg <= {shift_reg[6:0], sda};
                     bit_reg <= bit_reg + 3'h1;
                     if (bit_reg == `TWS_BIT_LAST) begin
                        state_reg <= tws_pkg::TWS_AACK;
                     end
                  end
               end
               tws_pkg::TWS_AACK: begin
                  if (sclFall) begin
                     if (hit & shift_reg[0]) begin
                        sdaDrive_reg <= 1'b1;
                     end else begin
                        state_reg <= tws_pkg::TWS_IGN;
                     end
                  end else if (sclRise & sdaDrive_reg) begin
                     state_reg <= tws_pkg::TWS_WAIT;
                     setFlag <= 1'b1;
                     setCode <= ctrl_reg.arbLost ? `TWS_ST_ARB_R : `TWS_ST_OWN_ADDRESS_READ; // RULE1 RULE2
                  end
               end
               tws_pkg::TWS_WAIT: begin
                  // RULE4: byte leaves once software clears the flag
                  if (!ctrl_reg.flag & (status_reg != `TWS_ST_BERR)) begin
                     if ((setCode == `TWS_ST_DNACK) | (setCode == `TWS_ST_LAST)) begin
                        state_reg <= tws_pkg::TWS_IGN; // RULE17
                        sdaDrive_reg <= 1'b0;
                     end else if (!scl) begin
                        shift_reg <= data_reg;
                        lastByte_reg <= ~ctrl_reg.ackEnable; // RULE4
                        bit_reg <= 3'h0;
                        sdaDrive_reg <= ~data_reg[7];
                        state_reg <= tws_pkg::TWS_TXD;
                     end
                  end else if (!ctrl_reg.flag) begin
                     state_reg <= tws_pkg::TWS_IDLE; // RULE15
                     sdaDrive_reg <= 1'b0;
                  end
               end
               tws_pkg::TWS_TXD: begin
                  if (sclFall) begin
                     bit_reg <= bit_reg + 3'h1;
                     if (bit_reg == `TWS_BIT_LAST) begin
                        sdaDrive_reg <= 1'b0;
                        state_reg <= tws_pkg::TWS_RACK;
                     end else begin
                        sdaDrive_reg <= ~shift_reg[3'h6 - bit_reg];
                     end
                  end
               end
               tws_pkg::TWS_RACK: begin
                  if (sclRise) begin
                     state_reg <= tws_pkg::TWS_WAIT;
                     setFlag <= 1'b1;
                     if (sda) begin
                        setCode <= `TWS_ST_DNACK; // RULE5
                     end else if (lastByte_reg) begin
                        setCode <= `TWS_ST_LAST; // RULE6
                     end else begin
                        setCode <= `TWS_ST_DACK; // RULE3
                     end
                  end
               end
               default: begin
                  sdaDrive_reg <= 1'b0; // RULE17
               end
            endcase
         end
      end
   end
   // clock stretch: in TWS_WAIT, hold scl low after its fall while the flag stands and status is not 00
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sclHold_reg <= 1'b0;
      end else begin
         sclHold_reg <= ctrl_reg.flag & (state_reg == tws_pkg::TWS_WAIT) & ~scl &
            (status_reg != `TWS_ST_BERR); // RULE18 RULE15
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sdaOut <= 1'b0;
         sdaOe <= 1'b0;
         sclOut <= 1'b0;
         sclOe <= 1'b0;
      end else begin
         sdaOe <= sdaDrive_reg;
         sclOe <= sclHold_reg;
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         status_reg <= `TWS_ST_IDLE;
      end else if (setFlag) begin
         status_reg <= setCode;
      end else if (!ctrl_reg.flag) begin
         status_reg <= `TWS_ST_IDLE; // RULE10
      end
   end
   // control register; hardware set of the flag beats a software clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_reg <= '0;
      end else begin
         if (wrStrobe & pwrite & (paddr == `TWS_OFF_CTRL)) begin
            ctrl_reg.ackEnable <= pwdata[`TWS_CB_ACK];
            ctrl_reg.startRequest <= pwdata[`TWS_CB_START];
            ctrl_reg.enable <= pwdata[`TWS_CB_EN];
            ctrl_reg.arbLost <= pwdata[`TWS_CB_ARB];
            // error recovery drops the stop request by itself
            ctrl_reg.stopRequest <= pwdata[`TWS_CB_STOP] &
               ~((status_reg == `TWS_ST_BERR) & pwdata[`TWS_CB_FLAG]); // RULE13 RULE14
         end
         if (setFlag) begin
            ctrl_reg.flag <= 1'b1; // RULE12
         end else if (flagClear) begin
            ctrl_reg.flag <= 1'b0; // RULE4
         end
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         busBusy_reg <= 1'b0;
         startPending <= 1'b0;
      end else begin
         if (startCond) begin
            busBusy_reg <= 1'b1;
         end else if (stopCond) begin
            busBusy_reg <= 1'b0;
         end
         if (flagClear & pwdata[`TWS_CB_START] &
            ((status_reg == `TWS_ST_DNACK) | (status_reg == `TWS_ST_LAST))) begin
            startPending <= 1'b1; // RULE8
         end else if (startPending & ~busBusy_reg & scl & sda) begin
            startPending <= 1'b0; // RULE8
         end
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         data_reg <= 8'h00;
         addr_reg <= 8'h00;
         irqMask_reg <= 2'b00;
      end else if (wrStrobe & pwrite) begin
         if (paddr == `TWS_OFF_DATA) begin
            data_reg <= pwdata[7:0]; // RULE4
         end
         if (paddr == `TWS_OFF_ADDR) begin
            addr_reg <= pwdata[7:0];
         end
         if (paddr == `TWS_OFF_MASK) begin
            irqMask_reg <= pwdata[1:0];
         end
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irqStat_reg <= 2'b00;
         irq <= 1'b0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == `TWS_IRQ_FLAG) ? setFlag : (setFlag & (setCode == `TWS_ST_BERR))) begin
               irqStat_reg[i] <= 1'b1;
            end else if (wrStrobe & pwrite & (paddr == `TWS_OFF_IRQ) & pwdata[i]) begin
               irqStat_reg[i] <= 1'b0;
            end
         end
         irq <= |(irqStat_reg & irqMask_reg);
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (rdStrobe) begin
         pslverr <= 1'b0;
         case (paddr)
            `TWS_OFF_CTRL: prdata <= {24'h00_0000, ctrl_reg};
            `TWS_OFF_STAT: prdata <= {24'h00_0000, status_reg[7:3], 3'b000}; // RULE16
            `TWS_OFF_DATA: prdata <= {24'h00_0000, data_reg};
            `TWS_OFF_ADDR: prdata <= {24'h00_0000, addr_reg};
            `TWS_OFF_IRQ: prdata <= {30'h0000_0000, irqStat_reg};
            `TWS_OFF_MASK: prdata <= {30'h0000_0000, irqMask_reg};
            default: begin
               prdata <= 32'h0000_0000;
               pslverr <= 1'b1;
            end
         endcase
      end
   end
   property p_berr;
      @(posedge clk) disable iff (reset)
         setFlag & (setCode == `TWS_ST_BERR) |=> (status_reg == `TWS_ST_BERR) & ctrl_reg.flag;
   endproperty
   a_berr: assert property (p_berr) else $error("bus error not reported"); // RULE11 RULE12
   property p_idle;
      @(posedge clk) disable iff (reset)
         !ctrl_reg.flag & !setFlag |=> status_reg == `TWS_ST_IDLE;
   endproperty
   a_idle: assert property (p_idle) else $error("status not idle with flag clear"); // RULE10
   property p_hold;
      @(posedge clk) disable iff (reset)
         sclOe |-> $past(ctrl_reg.flag, 2);
   endproperty
   a_hold: assert property (p_hold) else $error("clock held without flag"); // RULE18
   property p_ign;
      @(posedge clk) disable iff (reset)
         state_reg == tws_pkg::TWS_IGN |=> !sdaOe;
   endproperty
   a_ign: assert property (p_ign) else $error("data driven after last byte"); // RULE17
   property p_ack;
      @(posedge clk) disable iff (reset)
         (state_reg == tws_pkg::TWS_RACK) & sclRise & !sda & !lastByte_reg |=>
            setFlag & (setCode == `TWS_ST_DACK);
   endproperty
   a_ack: assert property (p_ack) else $error("acked byte not B8"); // RULE3
   property p_nack;
      @(posedge clk) disable iff (reset)
         (state_reg == tws_pkg::TWS_RACK) & sclRise & sda |=> setCode == `TWS_ST_DNACK;
   endproperty
   a_nack: assert property (p_nack) else $error("nacked byte not C0"); // RULE5
   property p_last;
      @(posedge clk) disable iff (reset)
         (state_reg == tws_pkg::TWS_RACK) & sclRise & !sda & lastByte_reg |=>
            setCode == `TWS_ST_LAST;
   endproperty
   a_last: assert property (p_last) else $error("acked last byte not C8"); // RULE6
   property p_stop;
      @(posedge clk) disable iff (reset)
         flagClear & pwdata[`TWS_CB_STOP] & (status_reg == `TWS_ST_BERR) |=>
            !ctrl_reg.stopRequest;
   endproperty
   a_stop: assert property (p_stop) else $error("stop request kept after recovery"); // RULE14
endmodule

// ---- tws_master_model.sv ----
// Purpose: bus master receiver model facing the slave transmitter
// Assumes: open-drain lines with pull-ups, wired in the bench
// Notes: one bit is 8 clk, 800 ns; lines stand still between frames
module tws_master_model (
   input wire logic clk,
   input wire logic scl,
   input wire logic sda,
   output logic sclOe,
   output logic sdaOe
);
   timeunit 1ns;
   timeprecision 1ns;
   int stuckCnt = 0;
   initial begin
      sclOe = 1'b0;
      sdaOe = 1'b0;
   end
   // the slave may stretch the low half; a bounded wait keeps a hang visible
   task automatic sclRelease();
      int n;
      sclOe <= 1'b0;
      for (n = 0; n < 5000; n++) begin
         @(posedge clk);
         if (scl === 1'b1) break;
      end
      if (n == 5000) stuckCnt++;
   endtask
   task automatic startCond();
      @(posedge clk);
      sdaOe <= 1'b1;
      repeat (4) @(posedge clk);
      sclOe <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   task automatic stopCond();
      @(posedge clk);
      sdaOe <= 1'b1;
      repeat (3) @(posedge clk);
      sclRelease();
      repeat (4) @(posedge clk);
      sdaOe <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   // sda moves one clk after scl falls so it never looks like start or stop
   // low half is 5 clk: the slave's data turns 4 clk after the fall and must
   // settle before scl rises, else the slave sees its own start or stop
   task automatic bitIo(input logic b, output logic r);
      @(posedge clk);
      sdaOe <= ~b;
      repeat (4) @(posedge clk);
      sclRelease();
      @(posedge clk);
      r = sda;
      @(posedge clk);
      sclOe <= 1'b1;
   endtask
   // msb first, then the acknowledge slot
   task automatic xferByte(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx,
                           output logic ackOut);
      for (int i = 7; i >= 0; i--) bitIo(tx[i], rx[i]);
      bitIo(ackIn, ackOut);
   endtask
endmodule

// ---- tws_top_test.sv ----
// Purpose: self-checking bench of the slave transmitter
// Assumes: APB master tasks, master receiver model on the wired lines
// Notes: own address 0x2A, read byte 0x55
`include "tws_defs.svh"
module tws_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, sclOut, sclOe, sdaOut, sdaOe, startPending, irq;
   logic mSclOe, mSdaOe, errSeen, ak;
   logic [7:0] rx;
   logic [31:0] r;
   wire logic sclW = ~(sclOe | mSclOe);
   wire logic sdaW = ~(sdaOe | mSdaOe);
   int n_mismatch = 0;
   int checked = 0;
   tws_top dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sclIn(sclW), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaW), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .startPending(startPending), .irq(irq));
   tws_master_model mst_u (.clk(clk), .scl(sclW), .sda(sdaW), .sclOe(mSclOe), .sdaOe(mSdaOe));
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (n == 50) begin
         n_mismatch++;
         report_and_stop();
      end
      r = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chkSt(input logic [7:0] code);
      apb(1'b0, `TWS_OFF_STAT, 32'h0000_0000);
      chk(r, {24'h00_0000, code});
   endtask
   task automatic waitIrq();
      int n;
      for (n = 0; n < 3000; n++) begin
         @(posedge clk);
         if (irq === 1'b1) break;
      end
      if (n == 3000) begin
         n_mismatch++;
         report_and_stop();
      end
   endtask
   initial begin
      repeat (90000) @(posedge clk);
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      chkSt(`TWS_ST_IDLE);
      apb(1'b0, 12'h01C, 32'h0000_0000);
      chk(r, 32'h0000_0000);
      chk({31'h0, errSeen}, 32'h0000_0001);
      apb(1'b1, `TWS_OFF_ADDR, 32'h0000_0054);
      apb(1'b1, `TWS_OFF_MASK, 32'h0000_0003);
      apb(1'b1, `TWS_OFF_CTRL, 32'h0000_0044);
      $display("setup done");
      mst_u.startCond();
      mst_u.xferByte(8'h55, 1'b1, rx, ak);
      chk({31'h0, ak}, 32'h0000_0000);
      waitIrq();
      chkSt(`TWS_ST_OWN_ADDRESS_READ);
      repeat (20) @(posedge clk);
      chk({31'h0, sclOe}, 32'h0000_0001);
      apb(1'b1, `TWS_OFF_IRQ, 32'h0000_0003);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0000_0000);
      apb(1'b1, `TWS_OFF_DATA, 32'h0000_00A5);
      apb(1'b1, `TWS_OFF_CTRL, 32'h0000_00C4);
      mst_u.xferByte(8'hFF, 1'b0, rx, ak);
      chk({24'h0, rx}, 32'h0000_00A5);
      waitIrq();
      chkSt(`TWS_ST_DACK);
      apb(1'b1, `TWS_OFF_IRQ, 32'h0000_0003);
      apb(1'b1, `TWS_OFF_DATA, 32'h0000_003C);
      apb(1'b1, `TWS_OFF_CTRL, 32'h0000_0084);
      mst_u.xferByte(8'hFF, 1'b0, rx, ak);
      chk({24'h0, rx}, 32'h0000_003C);
      waitIrq();
      chkSt(`TWS_ST_LAST);
      apb(1'b1, `TWS_OFF_IRQ, 32'h0000_0003);
      apb(1'b1, `TWS_OFF_CTRL, 32'h0000_0084);
      chkSt(`TWS_ST_IDLE);
      mst_u.xferByte(8'hFF, 1'b0, rx, ak);
      chk({24'h0, rx}, 32'h0000_00FF);
      mst_u.stopCond();
      mst_u.startCond();
      mst_u.xferByte(8'h55, 1'b1, rx, ak);
      chk({31'h0, ak}, 32'h0000_0001);
      mst_u.stopCond();
      $display("ack and last byte test done");
      apb(1'b1, `TWS_OFF_MASK, 32'h0000_0000);
      apb(1'b1, `TWS_OFF_CTRL, 32'h0000_0045);
      mst_u.startCond();
      mst_u.xferByte(8'h55, 1'b1, rx, ak);
      repeat (40) @(posedge clk);
      chk({31'h0, irq}, 32'h0000_0000);
      chkSt(`TWS_ST_ARB_R);
      apb(1'b1, `TWS_OFF_MASK, 32'h0000_0003);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0000_0001);
      apb(1'b1, `TWS_OFF_IRQ, 32'h0000_0003);
      apb(1'b1, `TWS_OFF_DATA, 32'h0000_0096);
      apb(1'b1, `TWS_OFF_CTRL, 32'h0000_00C4);
      mst_u.xferByte(8'hFF, 1'b1, rx, ak);
      chk({24'h0, rx}, 32'h0000_0096);
      waitIrq();
      chkSt(`TWS_ST_DNACK);
      apb(1'b1, `TWS_OFF_IRQ, 32'h0000_0003);
      apb(1'b1, `TWS_OFF_CTRL, 32'h0000_00E4);
      repeat (3) @(posedge clk);
      chk({31'h0, startPending}, 32'h0000_0001);
      mst_u.stopCond();
      repeat (20) @(posedge clk);
      chk({31'h0, startPending}, 32'h0000_0000);
      $display("arbitration and nack test done");
      mst_u.startCond();
      mst_u.bitIo(1'b0, ak);
      mst_u.bitIo(1'b1, ak);
      mst_u.bitIo(1'b0, ak);
      mst_u.stopCond();
      waitIrq();
      chkSt(`TWS_ST_BERR);
      apb(1'b0, `TWS_OFF_CTRL, 32'h0000_0000);
      chk({31'h0, r[`TWS_CB_FLAG]}, 32'h0000_0001);
      apb(1'b1, `TWS_OFF_CTRL, 32'h0000_00D4);
      apb(1'b0, `TWS_OFF_CTRL, 32'h0000_0000);
      chk({24'h0, r[7:0]}, 32'h0000_0044);
      chk({28'h0, sclOe, sdaOe, sclOut, sdaOut}, 32'h0000_0000);
      chkSt(`TWS_ST_IDLE);
      $display("bus error test done");
      apb(1'b1, `TWS_OFF_ADDR, 32'h0000_0055);
      mst_u.startCond();
      mst_u.xferByte(8'h01, 1'b1, rx, ak);
      chk({31'h0, ak}, 32'h0000_0000);
      waitIrq();
      chkSt(`TWS_ST_OWN_ADDRESS_READ);
      apb(1'b1, `TWS_OFF_IRQ, 32'h0000_0003);
      apb(1'b1, `TWS_OFF_DATA, 32'h0000_00FF);
      apb(1'b1, `TWS_OFF_CTRL, 32'h0000_0084);
      mst_u.xferByte(8'hFF, 1'b1, rx, ak);
      waitIrq();
      chkSt(`TWS_ST_DNACK);
      apb(1'b1, `TWS_OFF_IRQ, 32'h0000_0003);
      apb(1'b1, `TWS_OFF_CTRL, 32'h0000_0084);
      mst_u.stopCond();
      chk(mst_u.stuckCnt, 0);
      $display("general call test done");
      report_and_stop();
   end
endmodule
